// ===== verilog/meter_regs_pkg.sv
// Purpose : constants and types for the low register bank of the energy meter
// Assumes : one clock, synchronous active-high reset
// Notes   : addresses are the six-bit register addresses of the command byte
package meter_regs_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [5:0] ADDR_WAVEFORM_SAMPLE       = 6'h01;
  localparam logic [5:0] ADDR_ACTIVE_ENERGY_ACC     = 6'h02;
  localparam logic [5:0] ADDR_ACTIVE_ENERGY_COR     = 6'h03;
  localparam logic [5:0] ADDR_LINE_CYCLE_ACTIVE     = 6'h04;
  localparam logic [5:0] ADDR_APPARENT_ENERGY_ACC   = 6'h05;
  localparam logic [5:0] ADDR_APPARENT_ENERGY_COR   = 6'h06;
  localparam logic [5:0] ADDR_LINE_CYCLE_APPARENT   = 6'h07;
  localparam logic [5:0] ADDR_LINE_CYCLE_REACTIVE   = 6'h08;
  localparam logic [5:0] ADDR_OPERATING_MODE        = 6'h09;
  localparam logic [5:0] ADDR_INTERRUPT_ENABLE_MASK = 6'h0A;
  localparam logic [5:0] ADDR_INTERRUPT_FLAGS       = 6'h0B;
  localparam logic [5:0] ADDR_INTERRUPT_FLAGS_COR   = 6'h0C;
  localparam logic [5:0] ADDR_CURRENT_OFFSET_CTL    = 6'h0D;
  localparam logic [5:0] ADDR_VOLTAGE_OFFSET_ADJUST = 6'h0E;
  localparam logic [5:0] ADDR_AMPLIFIER_GAIN_SELECT = 6'h0F;
  localparam logic [5:0] ADDR_PHASE_CALIBRATION     = 6'h10;
  localparam logic [5:0] ADDR_ACTIVE_POWER_OFFSET   = 6'h11;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_OPERATING_MODE        = 16'h000C;
  localparam logic [15:0] RST_INTERRUPT_ENABLE_MASK = 16'h0040;
  localparam logic [7:0]  RST_CURRENT_OFFSET_CTL    = 8'h00;
  localparam logic [7:0]  RST_VOLTAGE_OFFSET_ADJUST = 8'h00;
  localparam logic [7:0]  RST_AMPLIFIER_GAIN_SELECT = 8'h00;
  localparam logic [5:0]  RST_PHASE_CALIBRATION     = 6'h0D;
  localparam logic [15:0] RST_ACTIVE_POWER_OFFSET   = 16'h0000;
  localparam logic [23:0] RST_ENERGY                = 24'h000000;

  // ==========================================================================
  // field positions and widths
  localparam int CMD_WRITE_BIT       = 7;
  localparam int MODE_WAVE_SEL_HI    = 14;
  localparam int MODE_WAVE_SEL_LO    = 13;
  localparam int OFFSET_FIELD_MSB    = 5;
  localparam int INTEGRATOR_EN_BIT   = 7;
  localparam int PHASE_CAL_MSB       = 5;
  localparam logic [1:0] BYTES_ONE   = 2'd1;
  localparam logic [1:0] BYTES_TWO   = 2'd2;
  localparam logic [1:0] BYTES_THREE = 2'd3;

  // waveform source codes in operating_mode[14:13]
  localparam logic [1:0] WAVE_SRC_ACTIVE_POWER = 2'b00;
  localparam logic [1:0] WAVE_SRC_CURRENT      = 2'b10;
  localparam logic [1:0] WAVE_SRC_VOLTAGE      = 2'b11;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic [23:0] current_sample;
    logic [23:0] voltage_sample;
    logic [23:0] active_power;
    logic [23:0] apparent_power;
    logic [23:0] reactive_power;
  } dsp_sample_type;

  typedef struct packed {
    logic       start;
    logic       valid;
    logic [7:0] data;
  } rx_byte_type;

  typedef struct packed {
    logic [5:0] current_offset;
    logic       integrator_en;
    logic [5:0] voltage_offset;
    logic [7:0] amplifier_gain;
    logic [5:0] phase_cal;
  } analog_ctl_type;

endpackage

// ===== verilog/energy_meter_register_bank_low.sv
// Purpose : low register bank (0x01..0x11) of a single-phase energy meter
// Assumes : serial engine delivers whole bytes; dsp delivers one sample set per valid
// Notes   : addresses outside 0x01..0x11 are left to other banks and read as zero here
`timescale 1ns/1ps

// Overview of operation
// - waveform register holds sample from source chosen by mode bits 14 and 13
// - active power integrates into signed 24-bit accumulator
// - clear-on-read copies read the accumulator, then restart it from the sample of the read cycle
// - line-cycle active energy accumulates over programmed half line cycles
// - apparent power integrates into unsigned 24-bit accumulator
// - line-cycle apparent energy, unsigned 24-bit, over programmed half cycles
// - line-cycle reactive energy, signed 24-bit, over programmed half cycles
// - 16-bit mode register, reset 0x000C, readable any time
// - interrupt enable mask, reset 0x40, gates only the request, not the flags
// - read-only flags register reports the source of each event
// - clear-on-read flags copy returns flags, then clears all but events set in that cycle
// - current offset uses bits 0 to 5; bit 6 does nothing
// - current offset register msb enables the integrator, default off
// - voltage offset bits 0 to 5 applied with inverted sign; bits 6, 7 unused
// - 8-bit gain register selects amplifier gain for both channels
// - signed 16-bit offset corrects active power before accumulation
// - each access starts with command byte: msb write, six lsbs address
// - data travels msb byte first, right justified; excess upper bits ignored
module energy_meter_register_bank_low
  import meter_regs_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire rx_byte_type    rx_byte,
  input  wire logic           tx_byte_req,
  output logic [7:0]          tx_byte_q,
  output logic                tx_active,
  input  wire dsp_sample_type dsp,
  input  wire logic           half_cycle_tick,
  input  wire logic [15:0]    half_cycle_count_reg,
  input  wire logic [15:0]    event_set,
  output logic                irq_request,
  output logic [15:0]         operating_mode,
  output analog_ctl_type      analog_ctl,
  output logic [15:0]         active_power_offset
);

  typedef enum logic [1:0] {
    ST_COMMAND,
    ST_WRITE,
    ST_READ
  } port_state_type;

  // ==========================================================================
  // declarations
  port_state_type        state_q;
  logic [5:0]            addr_q;
  logic [1:0]            bytes_left_q;
  logic [DATA_W-1:0]     wr_shift_q;
  logic [DATA_W-1:0]     rd_shift_q;
  logic [DATA_W-1:0]     rd_value;
  logic [1:0]            addr_bytes;
  logic [1:0]            cmd_bytes;
  logic                  wr_commit;
  logic [DATA_W-1:0]     wr_value;
  logic                  read_done;
  logic                  clr_active;
  logic                  clr_apparent;
  logic                  clr_flags;

  logic [DATA_W-1:0]     waveform_sample_q;
  logic [DATA_W-1:0]     active_energy_acc_q;
  logic [DATA_W-1:0]     apparent_energy_acc_q;
  logic [DATA_W-1:0]     line_cycle_active_energy_q;
  logic [DATA_W-1:0]     line_cycle_apparent_energy_q;
  logic [DATA_W-1:0]     line_cycle_reactive_energy_q;
  logic [DATA_W-1:0]     lc_active_run_q;
  logic [DATA_W-1:0]     lc_apparent_run_q;
  logic [DATA_W-1:0]     lc_reactive_run_q;
  logic [15:0]           half_cycle_seen_q;
  logic                  lc_end;
  logic [DATA_W-1:0]     power_corrected;
  logic [DATA_W-1:0]     active_add;
  logic [DATA_W-1:0]     apparent_add;
  logic [DATA_W-1:0]     reactive_add;

  logic [15:0]           operating_mode_q;
  logic [15:0]           interrupt_enable_mask_q;
  logic [15:0]           interrupt_flags_q;
  logic [7:0]            current_offset_integrator_ctl_q;
  logic [7:0]            voltage_offset_adjust_q;
  logic [7:0]            amplifier_gain_select_q;
  logic [5:0]            phase_calibration_q;
  logic [15:0]           active_power_offset_q;

  // ==========================================================================
  // register width in bytes and read mux
  always_comb begin
    addr_bytes = BYTES_THREE;
    unique case (addr_q)
      ADDR_OPERATING_MODE, ADDR_INTERRUPT_ENABLE_MASK, ADDR_INTERRUPT_FLAGS,
      ADDR_INTERRUPT_FLAGS_COR, ADDR_ACTIVE_POWER_OFFSET: addr_bytes = BYTES_TWO;
      ADDR_CURRENT_OFFSET_CTL, ADDR_VOLTAGE_OFFSET_ADJUST,
      ADDR_AMPLIFIER_GAIN_SELECT, ADDR_PHASE_CALIBRATION: addr_bytes = BYTES_ONE;
      default: addr_bytes = BYTES_THREE;
    endcase
  end

  // command decode uses the incoming address, not the stored one
  always_comb begin
    cmd_bytes = BYTES_THREE;
    unique case (rx_byte.data[5:0])
      ADDR_OPERATING_MODE, ADDR_INTERRUPT_ENABLE_MASK, ADDR_INTERRUPT_FLAGS,
      ADDR_INTERRUPT_FLAGS_COR, ADDR_ACTIVE_POWER_OFFSET: cmd_bytes = BYTES_TWO;
      ADDR_CURRENT_OFFSET_CTL, ADDR_VOLTAGE_OFFSET_ADJUST,
      ADDR_AMPLIFIER_GAIN_SELECT, ADDR_PHASE_CALIBRATION: cmd_bytes = BYTES_ONE;
      default: cmd_bytes = BYTES_THREE;
    endcase
  end

  always_comb begin
    rd_value = '0;
    unique case (rx_byte.data[5:0])
      ADDR_WAVEFORM_SAMPLE:       rd_value = waveform_sample_q;
      ADDR_ACTIVE_ENERGY_ACC,
      ADDR_ACTIVE_ENERGY_COR:     rd_value = active_energy_acc_q;
      ADDR_LINE_CYCLE_ACTIVE:     rd_value = line_cycle_active_energy_q;
      ADDR_APPARENT_ENERGY_ACC,
      ADDR_APPARENT_ENERGY_COR:   rd_value = apparent_energy_acc_q;
      ADDR_LINE_CYCLE_APPARENT:   rd_value = line_cycle_apparent_energy_q;
      ADDR_LINE_CYCLE_REACTIVE:   rd_value = line_cycle_reactive_energy_q;
      ADDR_OPERATING_MODE:        rd_value = {8'h00, operating_mode_q};
      ADDR_INTERRUPT_ENABLE_MASK: rd_value = {8'h00, interrupt_enable_mask_q};
      ADDR_INTERRUPT_FLAGS,
      ADDR_INTERRUPT_FLAGS_COR:   rd_value = {8'h00, interrupt_flags_q};
      ADDR_CURRENT_OFFSET_CTL:    rd_value = {16'h0000,
        current_offset_integrator_ctl_q[INTEGRATOR_EN_BIT], 1'b0,
        current_offset_integrator_ctl_q[OFFSET_FIELD_MSB:0]};
      ADDR_VOLTAGE_OFFSET_ADJUST: rd_value = {18'h00000,
        voltage_offset_adjust_q[OFFSET_FIELD_MSB:0]};
      ADDR_AMPLIFIER_GAIN_SELECT: rd_value = {16'h0000, amplifier_gain_select_q};
      ADDR_PHASE_CALIBRATION:     rd_value = {18'h00000, phase_calibration_q};
      ADDR_ACTIVE_POWER_OFFSET:   rd_value = {8'h00, active_power_offset_q};
      default:                    rd_value = '0;
    endcase
  end

  // ==========================================================================
  // communications protocol
  // last byte joins here, it is not yet in the shifter at the commit edge
  assign wr_value  = {wr_shift_q[DATA_W-9:0], rx_byte.data};
  assign wr_commit = (state_q == ST_WRITE) && rx_byte.valid && !rx_byte.start
                     && (bytes_left_q == BYTES_ONE);
  assign read_done = (state_q == ST_READ) && tx_byte_req && !rx_byte.start
                     && (bytes_left_q == BYTES_ONE);
  assign clr_active   = read_done && (addr_q == ADDR_ACTIVE_ENERGY_COR);
  assign clr_apparent = read_done && (addr_q == ADDR_APPARENT_ENERGY_COR);
  assign clr_flags    = read_done && (addr_q == ADDR_INTERRUPT_FLAGS_COR);
  assign tx_active    = (state_q == ST_READ);

  // a start pulse aborts any transfer; a half-written register keeps its value
  always_ff @(posedge mclk) begin
    if (rst || rx_byte.start) begin
      state_q      <= ST_COMMAND;
      addr_q       <= '0;
      bytes_left_q <= '0;
    end else begin
      unique case (state_q)
        ST_COMMAND: if (rx_byte.valid) begin
          addr_q       <= rx_byte.data[5:0];
          bytes_left_q <= cmd_bytes;
          state_q      <= rx_byte.data[CMD_WRITE_BIT] ? ST_WRITE : ST_READ;
        end
        ST_WRITE: if (rx_byte.valid) begin
          bytes_left_q <= bytes_left_q - 2'd1;
          if (bytes_left_q == BYTES_ONE) state_q <= ST_COMMAND;
        end
        ST_READ: if (tx_byte_req) begin
          bytes_left_q <= bytes_left_q - 2'd1;
          if (bytes_left_q == BYTES_ONE) state_q <= ST_COMMAND;
        end
      endcase
    end
  end

  // bytes shift in msb first; only the register's width is kept later
  always_ff @(posedge mclk) begin
    if (rst || rx_byte.start || state_q == ST_COMMAND) begin
      wr_shift_q <= '0;
    end else if (state_q == ST_WRITE && rx_byte.valid) begin
      wr_shift_q <= {wr_shift_q[DATA_W-9:0], rx_byte.data};
    end
  end

  // whole register is snapshotted at the command so multi-byte reads stay coherent
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_shift_q <= '0;
      tx_byte_q  <= '0;
    end else if (state_q == ST_COMMAND && rx_byte.valid && !rx_byte.start
                 && !rx_byte.data[CMD_WRITE_BIT]) begin
      unique case (cmd_bytes)
        BYTES_ONE: begin
          tx_byte_q  <= rd_value[7:0];
          rd_shift_q <= '0;
        end
        BYTES_TWO: begin
          tx_byte_q  <= rd_value[15:8];
          rd_shift_q <= {rd_value[7:0], 16'h0000};
        end
        default: begin
          tx_byte_q  <= rd_value[23:16];
          rd_shift_q <= {rd_value[15:0], 8'h00};
        end
      endcase
    end else if (state_q == ST_READ && tx_byte_req) begin
      tx_byte_q  <= rd_shift_q[DATA_W-1:DATA_W-8];
      rd_shift_q <= {rd_shift_q[DATA_W-9:0], 8'h00};
    end
  end

  // ==========================================================================
  // writable registers; read-only addresses fall through untouched
  always_ff @(posedge mclk) begin
    if (rst) begin
      operating_mode_q                <= RST_OPERATING_MODE;
      interrupt_enable_mask_q         <= RST_INTERRUPT_ENABLE_MASK;
      current_offset_integrator_ctl_q <= RST_CURRENT_OFFSET_CTL;
      voltage_offset_adjust_q         <= RST_VOLTAGE_OFFSET_ADJUST;
      amplifier_gain_select_q         <= RST_AMPLIFIER_GAIN_SELECT;
      phase_calibration_q             <= RST_PHASE_CALIBRATION;
      active_power_offset_q           <= RST_ACTIVE_POWER_OFFSET;
    end else if (wr_commit) begin
      unique case (addr_q)
        ADDR_OPERATING_MODE:        operating_mode_q <= wr_value[15:0];
        ADDR_INTERRUPT_ENABLE_MASK: interrupt_enable_mask_q <= wr_value[15:0];
        ADDR_CURRENT_OFFSET_CTL:    current_offset_integrator_ctl_q <= wr_value[7:0];
        ADDR_VOLTAGE_OFFSET_ADJUST: voltage_offset_adjust_q <= wr_value[7:0];
        ADDR_AMPLIFIER_GAIN_SELECT: amplifier_gain_select_q <= wr_value[7:0];
        // range is the host's duty; stored as written
        ADDR_PHASE_CALIBRATION:     phase_calibration_q <= wr_value[PHASE_CAL_MSB:0];
        ADDR_ACTIVE_POWER_OFFSET:   active_power_offset_q <= wr_value[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // control outputs
  assign operating_mode               = operating_mode_q;
  assign active_power_offset          = active_power_offset_q;
  assign analog_ctl.current_offset    = current_offset_integrator_ctl_q[OFFSET_FIELD_MSB:0];
  assign analog_ctl.integrator_en     = current_offset_integrator_ctl_q[INTEGRATOR_EN_BIT];
  // stored value is inverted, so negate to get the applied offset
  assign analog_ctl.voltage_offset    = 6'(-voltage_offset_adjust_q[OFFSET_FIELD_MSB:0]);
  assign analog_ctl.amplifier_gain    = amplifier_gain_select_q;
  assign analog_ctl.phase_cal         = phase_calibration_q;

  // ==========================================================================
  // waveform sampling
  always_ff @(posedge mclk) begin
    if (rst) begin
      waveform_sample_q <= '0;
    end else if (dsp.valid) begin
      unique case (operating_mode_q[MODE_WAVE_SEL_HI:MODE_WAVE_SEL_LO])
        WAVE_SRC_CURRENT: waveform_sample_q <= dsp.current_sample;
        WAVE_SRC_VOLTAGE: waveform_sample_q <= dsp.voltage_sample;
        default:          waveform_sample_q <= dsp.active_power;
      endcase
    end
  end

  // ==========================================================================
  // energy accumulation
  assign power_corrected = dsp.active_power
                           + {{(DATA_W-16){active_power_offset_q[15]}},
                              active_power_offset_q};
  assign active_add   = dsp.valid ? power_corrected : '0;
  assign apparent_add = dsp.valid ? dsp.apparent_power : '0;
  assign reactive_add = dsp.valid ? dsp.reactive_power : '0;

  // a sample that lands on the clearing read is kept, not lost
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_energy_acc_q <= RST_ENERGY;
    end else if (clr_active) begin
      active_energy_acc_q <= active_add;
    end else begin
      active_energy_acc_q <= active_energy_acc_q + active_add;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      apparent_energy_acc_q <= RST_ENERGY;
    end else if (clr_apparent) begin
      apparent_energy_acc_q <= apparent_add;
    end else begin
      apparent_energy_acc_q <= apparent_energy_acc_q + apparent_add;
    end
  end

  // ==========================================================================
  // line-cycle accumulation
  assign lc_end = half_cycle_tick && (half_cycle_seen_q + 16'd1 >= half_cycle_count_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      half_cycle_seen_q <= '0;
    end else if (lc_end) begin
      half_cycle_seen_q <= '0;
    end else if (half_cycle_tick) begin
      half_cycle_seen_q <= half_cycle_seen_q + 16'd1;
    end
  end

  // results latch at the period end with the current sample; running sums restart from zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      lc_active_run_q              <= RST_ENERGY;
      lc_apparent_run_q            <= RST_ENERGY;
      lc_reactive_run_q            <= RST_ENERGY;
      line_cycle_active_energy_q   <= RST_ENERGY;
      line_cycle_apparent_energy_q <= RST_ENERGY;
      line_cycle_reactive_energy_q <= RST_ENERGY;
    end else if (lc_end) begin
      line_cycle_active_energy_q   <= lc_active_run_q + active_add;
      line_cycle_apparent_energy_q <= lc_apparent_run_q + apparent_add;
      line_cycle_reactive_energy_q <= lc_reactive_run_q + reactive_add;
      lc_active_run_q              <= RST_ENERGY;
      lc_apparent_run_q            <= RST_ENERGY;
      lc_reactive_run_q            <= RST_ENERGY;
    end else begin
      lc_active_run_q              <= lc_active_run_q + active_add;
      lc_apparent_run_q            <= lc_apparent_run_q + apparent_add;
      lc_reactive_run_q            <= lc_reactive_run_q + reactive_add;
    end
  end

  // ==========================================================================
  // interrupt flags and request
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_flags_q <= '0;
    end else if (clr_flags) begin
      interrupt_flags_q <= event_set;
    end else begin
      interrupt_flags_q <= interrupt_flags_q | event_set;
    end
  end

  // mask gates only the request; flags record regardless
  assign irq_request = |(interrupt_flags_q & interrupt_enable_mask_q);

endmodule // energy_meter_register_bank_low

// ===== sim/meter_regs_chk.sv
// Purpose : port assertions for the low register bank
// Assumes : single clock mclk, synchronous active-high rst
// Notes   : bound to every instance of the bank
`timescale 1ns/1ps
module meter_regs_chk
  import meter_regs_pkg::*;
(
  input wire logic           mclk,
  input wire logic           rst,
  input wire rx_byte_type    rx_byte,
  input wire logic           tx_byte_req,
  input wire logic [7:0]     tx_byte_q,
  input wire logic           tx_active,
  input wire dsp_sample_type dsp,
  input wire logic           half_cycle_tick,
  input wire logic [15:0]    half_cycle_count_reg,
  input wire logic [15:0]    event_set,
  input wire logic           irq_request,
  input wire logic [15:0]    operating_mode,
  input wire analog_ctl_type analog_ctl,
  input wire logic [15:0]    active_power_offset
);
  // ==========================================================================
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_mode_reset: assert property ($fell(rst) |-> operating_mode == 16'h000C)
    else $error("mode reset value wrong");
  a_ctl_reset: assert property ($fell(rst) |-> analog_ctl.phase_cal == 6'h0D
    && !analog_ctl.integrator_en) else $error("control reset value wrong");
  a_idle_reset: assert property ($fell(rst) |-> !irq_request && !tx_active)
    else $error("irq or read active after reset");
  a_read_start: assert property ($rose(tx_active) |->
    $past(rx_byte.valid && !rx_byte.data[7])) else $error("read without read command");
  a_mode_write: assert property (!$stable(operating_mode) && !$past(rst) |->
    $past(rx_byte.valid)) else $error("mode changed without a byte");
  a_ctl_write: assert property (!$stable(analog_ctl) && !$past(rst) |->
    $past(rx_byte.valid)) else $error("control changed without a byte");
  a_offset_write: assert property (!$stable(active_power_offset) && !$past(rst) |->
    $past(rx_byte.valid)) else $error("offset changed without a byte");
  // a read byte must not slip while the host has not consumed it
  a_tx_hold: assert property (tx_active && $past(tx_active) && !$past(tx_byte_req
    || rx_byte.valid || rx_byte.start) |-> $stable(tx_byte_q)) else $error("tx byte moved");
  a_one_byte: assert property ($rose(tx_active) && tx_byte_req &&
    $past(rx_byte.data[5:0]) inside {[6'h0D:6'h10]} |=> !tx_active)
    else $error("one-byte read too long");
  a_three_bytes: assert property (($rose(tx_active) && $past(rx_byte.data[5:0]) < 6'h09)
    ##0 tx_byte_req [*3] |=> !tx_active) else $error("three-byte read length wrong");
endmodule // meter_regs_chk

bind energy_meter_register_bank_low meter_regs_chk u_chk (.mclk, .rst, .rx_byte,
  .tx_byte_req, .tx_byte_q, .tx_active, .dsp, .half_cycle_tick, .half_cycle_count_reg,
  .event_set, .irq_request, .operating_mode, .analog_ctl, .active_power_offset);

// ===== sim/meter_host_model.sv
// Purpose : host side of the byte port, frames register reads and writes
// Assumes : bytes change 1 ns after the rising edge of mclk
// Notes   : idle data lines show the inverse of the last byte
`timescale 1ns/1ps
module meter_host_model
  import meter_regs_pkg::*;
(
  input  wire logic       mclk,
  output rx_byte_type     rx_byte,
  output logic            tx_byte_req,
  input  wire logic [7:0] tx_byte_q
);
  // ==========================================================================
  // byte tasks
  initial begin
    rx_byte = '0;
    tx_byte_req = 1'b0;
  end
  task automatic put(input logic s, input logic v, input logic [7:0] d);
    @(posedge mclk) #1;
    rx_byte = '{start: s, valid: v, data: d};
  endtask
  // a new frame also aborts a write left short
  task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b1, {2'b10, a});
    for (int i = n - 1; i >= 0; i--) put(1'b0, 1'b1, d[8*i +: 8]);
    put(1'b0, 1'b0, ~rx_byte.data);
  endtask
  task automatic rd(input logic [5:0] a, input int n, output logic [23:0] d);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b1, {2'b00, a});
    put(1'b0, 1'b0, ~rx_byte.data);
    d = '0;
    for (int i = 0; i < n; i++) begin
      d = {d[15:0], tx_byte_q};
      tx_byte_req = 1'b1;
      @(posedge mclk) #1;
      // 16-bit reads pause so the tx byte must hold
      if (n == 2) begin
        tx_byte_req = 1'b0;
        @(posedge mclk) #1;
      end
    end
    tx_byte_req = 1'b0;
  endtask
endmodule // meter_host_model

// ===== sim/energy_meter_register_bank_low_tb.sv
// Purpose : self-checking bench for the low register bank
// Assumes : host model drives the byte port
// Notes   : accumulators modelled with 24-bit wrap
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module energy_meter_register_bank_low_tb
  import meter_regs_pkg::*;
();
  logic           mclk, rst, tx_byte_req, tx_active, irq_request, half_cycle_tick;
  rx_byte_type    rx_byte;
  logic [7:0]     tx_byte_q;
  dsp_sample_type dsp;
  logic [15:0]    half_cycle_count_reg, event_set, operating_mode, active_power_offset, flags;
  analog_ctl_type analog_ctl;
  logic [23:0]    rv, acc_a, acc_va, lc [3], lq [3], regv [64];
  logic [5:0]     a;
  logic [5:0]     rw [7] = '{6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11};
  logic [1:0]     codes [3] = '{WAVE_SRC_ACTIVE_POWER, WAVE_SRC_CURRENT, WAVE_SRC_VOLTAGE};
  int             n_fail, checks_done, cnt;

  always #25 mclk = ~mclk;
  energy_meter_register_bank_low DUT (.mclk, .rst, .rx_byte, .tx_byte_req, .tx_byte_q,
    .tx_active, .dsp, .half_cycle_tick, .half_cycle_count_reg, .event_set, .irq_request,
    .operating_mode, .analog_ctl, .active_power_offset);
  meter_host_model host (.mclk, .rx_byte, .tx_byte_req, .tx_byte_q);

  // ==========================================================================
  // expectations and stimulus
  function automatic int nb(logic [5:0] x);
    if (x >= 6'h0D && x <= 6'h10) return 1;
    return (x >= 6'h09 && x <= 6'h11) ? 2 : 3;
  endfunction
  function automatic logic [23:0] rmask(logic [5:0] x);
    case (x)
      6'h09, 6'h0A, 6'h11: return 24'h00FFFF;
      6'h0D: return 24'h0000BF;
      6'h0F: return 24'h0000FF;
      6'h0E, 6'h10: return 24'h00003F;
      default: return 24'h000000;
    endcase
  endfunction
  task automatic rchk(logic [5:0] x, logic [23:0] e);
    host.rd(x, nb(x), rv);
    `CHK(rv, e)
  endtask
  task automatic sample();
    @(posedge mclk) #1;
    dsp = {1'b1, 24'($urandom), 24'($urandom), 24'($urandom_range(0, 511)) - 24'd256,
           24'($urandom_range(0, 255)), 24'($urandom_range(0, 511)) - 24'd256};
    acc_a += dsp.active_power + {{8{regv[17][15]}}, regv[17][15:0]};
    acc_va += dsp.apparent_power;
    lc[0] += dsp.active_power;
    lc[1] += dsp.apparent_power;
    lc[2] += dsp.reactive_power;
    @(posedge mclk) #1;
    dsp.valid = 1'b0;
  endtask
  task automatic tick();
    @(posedge mclk) #1;
    half_cycle_tick = 1'b1;
    @(posedge mclk) #1;
    half_cycle_tick = 1'b0;
    cnt++;
    if (cnt >= half_cycle_count_reg) begin
      lq = lc;
      lc = '{3{24'h0}};
      cnt = 0;
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {mclk, rst, half_cycle_tick, dsp, event_set, acc_a, acc_va} = '0;
    rst = 1'b1;
    {n_fail, checks_done, cnt} = '0;
    foreach (regv[i]) regv[i] = 24'h0;
    lc = '{3{24'h0}};
    lq = lc;
    regv[9] = 24'h00000C;
    regv[10] = 24'h000040;
    regv[16] = 24'h00000D;
    void'($urandom(32'h833A));
    half_cycle_count_reg = 16'(2 + $urandom_range(0, 2));
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 1; i <= 17; i++) rchk(6'(i), regv[i] & rmask(6'(i)));
    rchk(6'h3F, 24'h0);
    repeat (5) begin
      sample();
      tick();
    end
    rchk(ADDR_LINE_CYCLE_ACTIVE, lq[0]);
    rchk(ADDR_LINE_CYCLE_APPARENT, lq[1]);
    rchk(ADDR_LINE_CYCLE_REACTIVE, lq[2]);
    foreach (codes[i]) begin
      regv[9] = {9'h0, codes[i], 13'h000C};
      host.wr(ADDR_OPERATING_MODE, 2, regv[9]);
      sample();
      rv = (codes[i] == WAVE_SRC_ACTIVE_POWER) ? dsp.active_power :
           (codes[i] == WAVE_SRC_CURRENT) ? dsp.current_sample : dsp.voltage_sample;
      rchk(ADDR_WAVEFORM_SAMPLE, rv);
    end
    host.wr(ADDR_ACTIVE_ENERGY_ACC, 3, 24'h5A5A5A);
    host.wr(ADDR_INTERRUPT_FLAGS, 2, 24'h00FFFF);
    rchk(ADDR_ACTIVE_ENERGY_ACC, acc_a);
    rchk(ADDR_APPARENT_ENERGY_ACC, acc_va);
    rchk(ADDR_ACTIVE_ENERGY_COR, acc_a);
    acc_a = '0;
    rchk(ADDR_ACTIVE_ENERGY_ACC, acc_a);
    rchk(ADDR_APPARENT_ENERGY_COR, acc_va);
    acc_va = '0;
    rchk(ADDR_APPARENT_ENERGY_ACC, acc_va);
    foreach (rw[i]) begin
      a = rw[i];
      // phase calibration kept inside the legal window
      rv = (a == ADDR_PHASE_CALIBRATION) ? 24'(6'h1D + $urandom_range(0, 4)) : 24'($urandom);
      host.wr(a, nb(a), rv);
      regv[a] = rv & rmask(a);
      rchk(a, regv[a]);
    end
    `CHK(operating_mode, regv[9][15:0])
    `CHK(active_power_offset, regv[17][15:0])
    `CHK(analog_ctl.current_offset, regv[13][5:0])
    `CHK(analog_ctl.integrator_en, regv[13][7])
    `CHK(analog_ctl.voltage_offset, 6'(-regv[14][5:0]))
    `CHK(analog_ctl.amplifier_gain, regv[15][7:0])
    `CHK(analog_ctl.phase_cal, regv[16][5:0])
    sample();
    rchk(ADDR_ACTIVE_ENERGY_ACC, acc_a);
    @(posedge mclk) #1;
    event_set = 16'($urandom) | 16'h0040;
    flags = event_set;
    @(posedge mclk) #1;
    event_set = 16'h0000;
    @(posedge mclk) #1;
    `CHK(irq_request, |(flags & regv[10][15:0]))
    rchk(ADDR_INTERRUPT_FLAGS, 24'(flags));
    host.wr(ADDR_INTERRUPT_ENABLE_MASK, 2, 24'h0);
    @(posedge mclk) #1;
    `CHK(irq_request, 1'b0)
    rchk(ADDR_INTERRUPT_FLAGS_COR, 24'(flags));
    rchk(ADDR_INTERRUPT_FLAGS, 24'h0);
    host.wr(ADDR_ACTIVE_POWER_OFFSET, 1, 24'h0000A5);
    rchk(ADDR_ACTIVE_POWER_OFFSET, regv[17]);
    report_and_stop();
  end
endmodule // energy_meter_register_bank_low_tb
